// >>> src/core_clock_and_reference_output.sv
// per-core clock control, rc source control, failsafe and reference output
`timescale 1ns/10ps
module core_clock_and_reference_output (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// system clock ticks and source status
	input wire logic sysclk_tick,
	input wire logic backup_rc_tick,
	input wire logic [15:0] ref_src_ticks,
	input wire logic [15:0] ref_src_sleep_ok,
	input wire logic sleep_mode,
	input wire logic power_up_timer_done,
	input wire logic low_power_rc_selected,
	// configuration bits
	input wire logic [7:0] osc_config,
	input wire logic [1:0] primary_osc_mode_field,
	input wire logic osc_pin_function_bit,
	input wire logic other_core_failsafe_on,
	input wire logic watchdog_on,
	input wire logic other_core_watchdog_on,
	// auxiliary pll control
	input wire logic aux_pll_enable,
	input wire logic periph_clk_request,
	// tuning register write
	input wire logic tune_wr,
	input wire logic [5:0] tune_wdata,
	// oscillator control byte writes, one instr_step per instruction
	input wire logic instr_step,
	input wire logic osc_high_wr,
	input wire logic osc_low_wr,
	input wire logic [7:0] osc_wdata,
	// reference control writes
	input wire logic ref_low_wr,
	input wire logic [15:0] ref_low_wdata,
	input wire logic ref_high_wr,
	input wire logic [14:0] ref_divisor_wdata,
	input wire logic ref_trim_wr,
	input wire logic [8:0] ref_trim_wdata,
	input wire logic ref_pin_output_enable,
	// clock outputs
	output logic instr_clk,
	output logic osc_output_pin,
	output logic half_sysclk_output,
	output logic ref_clock_out_pin,
	output logic aux_pll_run,
	output logic low_power_rc_enable,
	// status
	output logic failsafe_switched,
	output logic [5:0] rc_tune_field,
	output logic [7:0] osc_ctrl_high,
	output logic [7:0] osc_ctrl_low,
	output logic [15:0] ref_ctrl_low,
	output logic [14:0] ref_integer_divisor,
	output logic [8:0] ref_fraction_trim
);
	typedef struct packed {
		logic fcy;
		logic osc_pin;
		logic half_out;
		logic ref_pin;
		logic apll;
		logic lp_rc;
		logic lp_rc_boot;
		logic fail;
		logic [3:0] fail_cnt;
		logic [5:0] tune;
		logic [7:0] osc_hi;
		logic [7:0] osc_lo;
		logic ref_en;
		logic ref_slp;
		logic ref_sw;
		logic ref_act;
		logic [3:0] ref_src;
		logic [14:0] div_new;
		logic [8:0] trim_new;
		logic [14:0] div_use;
		logic [8:0] trim_use;
	} state_t;
	state_t s_q;
	state_t s_d;

	logic hi_accept;
	logic lo_accept;
	logic sel_tick;
	logic ref_run;
	logic ref_lvl;
	logic ref_edge;
	logic failsafe_on;
	logic clk_tick;

	// separate locks for each byte
	byte_key_lock u_high_lock (
		.mclk(mclk),
		.rst(rst),
		.key_first(clk_ctrl_pkg::high_key_first),
		.key_second(clk_ctrl_pkg::high_key_second),
		.instr_step(instr_step),
		.wr_en(osc_high_wr),
		.wr_data(osc_wdata),
		.accept(hi_accept)
	);

	byte_key_lock u_low_lock (
		.mclk(mclk),
		.rst(rst),
		.key_first(clk_ctrl_pkg::low_key_first),
		.key_second(clk_ctrl_pkg::low_key_second),
		.instr_step(instr_step),
		.wr_en(osc_low_wr),
		.wr_data(osc_wdata),
		.accept(lo_accept)
	);

	frac_ref_divider u_div (
		.mclk(mclk),
		.rst(rst),
		.run(ref_run),
		.src_tick(sel_tick),
		.divisor(s_q.div_use),
		.trim(s_q.trim_use),
		.ref_level(ref_lvl),
		.half_period_done(ref_edge)
	);

	always_comb
	begin
		failsafe_on = osc_config[clk_ctrl_pkg::failsafe_field_msb:
			clk_ctrl_pkg::failsafe_field_lsb]
			== clk_ctrl_pkg::failsafe_monitor_on;
		// after failure the system clock is the backup rc
		clk_tick = s_q.fail ? backup_rc_tick : sysclk_tick;
		// source zero follows the system clock, whatever it is
		if (s_q.ref_src == clk_ctrl_pkg::ref_src_sysclk)
			sel_tick = clk_tick;
		else
			sel_tick = ref_src_ticks[s_q.ref_src];
		// sleep needs the sleep bit and a live source
		ref_run = s_q.ref_en && (!sleep_mode
			|| (s_q.ref_slp && ref_src_sleep_ok[s_q.ref_src]));
	end

	always_comb
	begin
		s_d = s_q;
		// instruction clock toggles each system clock tick
		if (clk_tick)
			s_d.fcy = ~s_q.fcy;
		s_d.half_out = osc_pin_function_bit & s_q.fcy;
		// no cycle clock on osc pin in crystal modes
		s_d.osc_pin = s_q.fcy
			&& primary_osc_mode_field != clk_ctrl_pkg::high_speed_crystal_mode
			&& primary_osc_mode_field != clk_ctrl_pkg::medium_crystal_mode;
		s_d.apll = aux_pll_enable & periph_clk_request;
		if (tune_wr)
			s_d.tune = tune_wdata;
		// rc source: boot hold until power-up timer, then by demand
		if (power_up_timer_done)
			s_d.lp_rc_boot = 1'b0;
		s_d.lp_rc = !sleep_mode && (s_q.lp_rc_boot || failsafe_on
			|| other_core_failsafe_on || watchdog_on
			|| other_core_watchdog_on || low_power_rc_selected);
		// main clock must tick within window of backup rc ticks
		if (!failsafe_on || s_q.fail || sysclk_tick)
			s_d.fail_cnt = '0;
		else if (backup_rc_tick)
		begin
			if (s_q.fail_cnt == clk_ctrl_pkg::fail_window)
				s_d.fail = 1'b1;
			else
				s_d.fail_cnt = 4'(s_q.fail_cnt + 4'h1);
		end
		if (hi_accept)
			s_d.osc_hi = osc_wdata;
		if (lo_accept)
			s_d.osc_lo = osc_wdata;
		if (ref_low_wr)
		begin
			s_d.ref_en = ref_low_wdata[clk_ctrl_pkg::ref_enable_bit];
			s_d.ref_slp = ref_low_wdata[clk_ctrl_pkg::ref_sleep_bit];
			s_d.ref_src = ref_low_wdata[clk_ctrl_pkg::ref_src_msb:
				clk_ctrl_pkg::ref_src_lsb];
		end
		if (ref_high_wr)
			s_d.div_new = ref_divisor_wdata;
		if (ref_trim_wr)
			s_d.trim_new = ref_trim_wdata;
		// apply new divider at a half period boundary or when idle
		if (s_q.ref_sw && (ref_edge || !ref_run))
		begin
			s_d.div_use = s_q.div_new;
			s_d.trim_use = s_q.trim_new;
			s_d.ref_sw = 1'b0;
		end
		// a new request in the apply cycle stays pending
		if (ref_low_wr && ref_low_wdata[clk_ctrl_pkg::ref_switch_bit])
			s_d.ref_sw = 1'b1;
		// active follows the run state; after disable holds while the level is still high
		s_d.ref_act = ref_run || (s_q.ref_act && ref_lvl);
		s_d.ref_pin = ref_run & ref_pin_output_enable & ref_lvl;
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			s_q <= '0;
			s_q.lp_rc <= 1'b1;
			s_q.lp_rc_boot <= 1'b1;
			s_q.tune <= clk_ctrl_pkg::tune_reset;
			s_q.osc_hi <= clk_ctrl_pkg::osc_high_reset;
			s_q.osc_lo <= clk_ctrl_pkg::osc_low_reset;
		end
		else
			s_q <= s_d;
	end

	assign instr_clk = s_q.fcy;
	assign osc_output_pin = s_q.osc_pin;
	assign half_sysclk_output = s_q.half_out;
	assign ref_clock_out_pin = s_q.ref_pin;
	assign aux_pll_run = s_q.apll;
	assign low_power_rc_enable = s_q.lp_rc;
	assign failsafe_switched = s_q.fail;
	assign rc_tune_field = s_q.tune;
	assign osc_ctrl_high = s_q.osc_hi;
	assign osc_ctrl_low = s_q.osc_lo;
	assign ref_ctrl_low = {s_q.ref_en, 3'h0, s_q.ref_slp, 1'b0, s_q.ref_sw,
		s_q.ref_act, 4'h0, s_q.ref_src};
	assign ref_integer_divisor = s_q.div_use;
	assign ref_fraction_trim = s_q.trim_use;
endmodule : core_clock_and_reference_output

// >>> src/clk_ctrl_pkg.sv
// shared constants and types for the core clock and reference output block
package clk_ctrl_pkg;
	// primary oscillator mode field encodings
	localparam logic [1:0] external_clock_mode = 2'h0;
	localparam logic [1:0] medium_crystal_mode = 2'h1;
	localparam logic [1:0] high_speed_crystal_mode = 2'h2;
	// failsafe config field values; monitoring on when bits 7 and 6 of it are both clear
	localparam int failsafe_field_msb = 7;
	localparam int failsafe_field_lsb = 6;
	localparam logic [1:0] failsafe_monitor_on = 2'h0;
	// reference control low bit positions
	localparam int ref_enable_bit = 15;
	localparam int ref_sleep_bit = 11;
	localparam int ref_switch_bit = 9;
	localparam int ref_active_bit = 8;
	localparam int ref_src_msb = 3;
	localparam int ref_src_lsb = 0;
	localparam int divisor_width = 15;
	localparam int trim_width = 9;
	localparam int tune_width = 6;
	// fractional trim weight, 512 steps per unit of divisor
	localparam logic [trim_width:0] trim_steps = 10'h200;
	localparam logic [3:0] ref_src_sysclk = 4'h0;
	// key bytes for the oscillator control byte locks
	localparam logic [7:0] high_key_first = 8'h78;
	localparam logic [7:0] high_key_second = 8'h9a;
	localparam logic [7:0] low_key_first = 8'h46;
	localparam logic [7:0] low_key_second = 8'h57;
	// reset values
	localparam logic [7:0] osc_high_reset = 8'h00;
	localparam logic [7:0] osc_low_reset = 8'h00;
	localparam logic [5:0] tune_reset = 6'h00;
	// backup rc reference rate and failure window in backup rc ticks
	localparam int backup_rc_mhz = 8;
	localparam int clock_mhz = 20;
	localparam int fail_window_cycles = 4 * clock_mhz / backup_rc_mhz;
	localparam logic [3:0] fail_window = 4'(fail_window_cycles);

	typedef enum logic [1:0] {key_idle, key_half, key_open} key_state_t;
endpackage : clk_ctrl_pkg

// >>> src/byte_key_lock.sv
// two-write key lock guarding one byte of the oscillator control register
`timescale 1ns/10ps
module byte_key_lock (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// key values
	input wire logic [7:0] key_first,
	input wire logic [7:0] key_second,
	// instruction stream
	input wire logic instr_step,
	input wire logic wr_en,
	input wire logic [7:0] wr_data,
	// write that may land on the byte
	output logic accept
);
	typedef struct packed {
		clk_ctrl_pkg::key_state_t st;
	} lock_t;
	lock_t s_q;
	lock_t s_d;

	always_comb
	begin
		s_d = s_q;
		accept = 1'b0;
		if (instr_step)
		begin
			case (s_q.st)
				clk_ctrl_pkg::key_idle:
					if (wr_en && wr_data == key_first)
						s_d.st = clk_ctrl_pkg::key_half;
				clk_ctrl_pkg::key_half:
				begin
					// second key must be the very next instruction
					if (wr_en && wr_data == key_second)
						s_d.st = clk_ctrl_pkg::key_open;
					else if (wr_en && wr_data == key_first)
						s_d.st = clk_ctrl_pkg::key_half;
					else
						s_d.st = clk_ctrl_pkg::key_idle;
				end
				clk_ctrl_pkg::key_open:
				begin
					// one instruction only, then relock
					accept = wr_en;
					s_d.st = clk_ctrl_pkg::key_idle;
				end
				default:
					s_d.st = clk_ctrl_pkg::key_idle;
			endcase
		end
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			s_q <= '{st: clk_ctrl_pkg::key_idle};
		else
			s_q <= s_d;
	end
endmodule : byte_key_lock

// >>> src/frac_ref_divider.sv
// fractional divider producing the reference clock as a level toggling on mclk
`timescale 1ns/10ps
module frac_ref_divider (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// control
	input wire logic run,
	input wire logic src_tick,
	input wire logic [14:0] divisor,
	input wire logic [8:0] trim,
	// output
	output logic ref_level,
	output logic half_period_done
);
	// accumulator counts in 1/512 units of source ticks
	typedef struct packed {
		logic [24:0] acc;
		logic lvl;
	} div_t;
	div_t s_q;
	div_t s_d;
	logic [24:0] half_span;

	always_comb
	begin
		// half period = divisor + trim/512 source ticks
		half_span = {1'b0, divisor, trim};
		s_d = s_q;
		half_period_done = 1'b0;
		if (!run)
		begin
			s_d.acc = '0;
			s_d.lvl = 1'b0;
		end
		else if (src_tick)
		begin
			if (divisor == '0)
			begin
				// undivided pass through of source
				s_d.lvl = ~s_q.lvl;
				half_period_done = 1'b1;
			end
			else if (s_q.acc + 25'(clk_ctrl_pkg::trim_steps) >= half_span)
			begin
				s_d.acc = 25'(s_q.acc + 25'(clk_ctrl_pkg::trim_steps)
					- half_span);
				s_d.lvl = ~s_q.lvl;
				half_period_done = 1'b1;
			end
			else
				s_d.acc = 25'(s_q.acc + 25'(clk_ctrl_pkg::trim_steps));
		end
	end

	assign ref_level = s_q.lvl;

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			s_q <= '{acc: '0, lvl: 1'b0};
		else
			s_q <= s_d;
	end
endmodule : frac_ref_divider

// >>> tb/core_clock_and_reference_output_properties.sv
// port assertions for the core clock and reference output block
`timescale 1ns/10ps
module core_clock_and_reference_output_properties (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// control inputs
	input wire logic aux_pll_enable,
	input wire logic periph_clk_request,
	input wire logic sleep_mode,
	input wire logic tune_wr,
	input wire logic [5:0] tune_wdata,
	input wire logic [7:0] osc_config,
	input wire logic ref_low_wr,
	input wire logic [15:0] ref_low_wdata,
	input wire logic ref_pin_output_enable,
	input wire logic [1:0] primary_osc_mode_field,
	// design outputs
	input wire logic aux_pll_run,
	input wire logic low_power_rc_enable,
	input wire logic [5:0] rc_tune_field,
	input wire logic failsafe_switched,
	input wire logic [15:0] ref_ctrl_low,
	input wire logic ref_clock_out_pin,
	input wire logic osc_output_pin
);
	default clocking @(posedge mclk);
	endclocking
	default disable iff (rst);
	AST_PLL_REQUEST: assert property (
		##1 aux_pll_run == $past(aux_pll_enable && periph_clk_request))
		else $error("aux pll run wrong");
	AST_SLEEP_LP_RC: assert property (
		sleep_mode |=> !low_power_rc_enable)
		else $error("low-power rc on in sleep");
	AST_TUNE_WRITE: assert property (
		tune_wr |=> rc_tune_field == $past(tune_wdata))
		else $error("tune field not written");
	AST_FAILSAFE_STICKY: assert property (
		failsafe_switched |=> failsafe_switched)
		else $error("failsafe switch dropped");
	AST_FAILSAFE_OFF: assert property (
		osc_config[7:6] != 2'h0 && !failsafe_switched |=> !failsafe_switched)
		else $error("failsafe switched with monitor off");
	AST_SWITCH_SET: assert property (
		ref_low_wr && ref_low_wdata[9] |=> ref_ctrl_low[9])
		else $error("divider switch bit not set");
	AST_PIN_GATE: assert property (
		!ref_pin_output_enable |=> !ref_clock_out_pin)
		else $error("reference pin driven while gated");
	AST_CRYSTAL_PIN: assert property (
		primary_osc_mode_field inside {2'h1, 2'h2} |=> !osc_output_pin)
		else $error("clock on osc pin in crystal mode");
endmodule : core_clock_and_reference_output_properties
bind core_clock_and_reference_output
	core_clock_and_reference_output_properties i_props (.*);

// >>> tb/core_clock_and_reference_output_test.sv
// self-checking bench for the core clock and reference output block
`timescale 1ns/10ps
module core_clock_and_reference_output_test;
	logic mclk = 0, rst = 1, sysclk_tick = 0, backup_rc_tick = 0;
	logic sleep_mode = 0, power_up_timer_done = 0;
	logic low_power_rc_selected = 0;
	logic osc_pin_function_bit = 0, other_core_failsafe_on = 0;
	logic watchdog_on = 0, other_core_watchdog_on = 0, aux_pll_enable = 0;
	logic periph_clk_request = 0, tune_wr = 0, instr_step = 0;
	logic osc_high_wr = 0, osc_low_wr = 0, ref_low_wr = 0, ref_high_wr = 0;
	logic ref_trim_wr = 0, ref_pin_output_enable = 0;
	logic sys_on = 0, bk_on = 0, src1_on = 0;
	logic [15:0] ref_src_ticks = 0, ref_src_sleep_ok = 0, ref_low_wdata = 0;
	logic [7:0] osc_config = 8'hc0, osc_wdata = 0;
	logic [1:0] primary_osc_mode_field = 0;
	logic [5:0] tune_wdata = 0;
	logic [14:0] ref_divisor_wdata = 0;
	logic [8:0] ref_trim_wdata = 0;
	logic instr_clk, osc_output_pin, half_sysclk_output, ref_clock_out_pin;
	logic aux_pll_run, low_power_rc_enable, failsafe_switched;
	logic [5:0] rc_tune_field;
	logic [7:0] osc_ctrl_high, osc_ctrl_low;
	logic [15:0] ref_ctrl_low;
	logic [14:0] ref_integer_divisor;
	logic [8:0] ref_fraction_trim;
	int errors = 0, checked = 0, r;
	core_clock_and_reference_output i_core_clock_and_reference_output (.*);
	always #25 mclk = ~mclk;
	// source tick streams: system and source 1 every cycle, backup every other
	always @(posedge mclk)
	begin
		sysclk_tick <= #1 sys_on;
		backup_rc_tick <= #1 bk_on & ~backup_rc_tick;
		ref_src_ticks <= #1 {14'h0, src1_on, 1'b0};
	end
	task step;
		@(posedge mclk);
		#1;
	endtask : step
	task check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			errors++;
			$display("MISMATCH %0t seen %0h expected %0h", $time, seen, exp);
		end
	endtask : check
	task complete_run;
		if (errors == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : complete_run
	function logic pick(input int s);
		case (s)
			0: return instr_clk;
			1: return half_sysclk_output;
			2: return osc_output_pin;
			default: return ref_clock_out_pin;
		endcase
	endfunction : pick
	task rises(input int s, input int n);
		logic p;
		repeat (2) step;
		r = 0;
		p = pick(s);
		repeat (n)
		begin
			step;
			if (pick(s) === 1'b1 && p === 1'b0)
				r++;
			p = pick(s);
		end
	endtask : rises
	task key(input logic hi, input logic [7:0] d);
		instr_step = 1;
		osc_high_wr = hi;
		osc_low_wr = !hi;
		osc_wdata = d;
		step;
	endtask : key
	task idle;
		instr_step = 0;
		step;
	endtask : idle
	task t_pll;
		check({instr_clk, aux_pll_run, failsafe_switched,
			low_power_rc_enable}, 1);
		aux_pll_enable = 1;
		repeat (2) step;
		check(aux_pll_run, 0);
		periph_clk_request = 1;
		repeat (2) step;
		check(aux_pll_run, 1);
		tune_wr = 1;
		tune_wdata = 6'h2a;
		step;
		tune_wr = 0;
		step;
		check(rc_tune_field, 6'h2a);
	endtask : t_pll
	task t_low_power_rc_source;
		power_up_timer_done = 1;
		repeat (3) step;
		check(low_power_rc_enable, 0);
		for (int i = 0; i < 4; i++)
		begin
			{watchdog_on, other_core_watchdog_on, other_core_failsafe_on,
				low_power_rc_selected} = 4'h1 << i;
			repeat (2) step;
			check(low_power_rc_enable, 1);
			sleep_mode = 1;
			repeat (2) step;
			check(low_power_rc_enable, 0);
			sleep_mode = 0;
		end
		low_power_rc_selected = 0;
	endtask : t_low_power_rc_source
	task t_clk;
		sys_on = 1;
		osc_pin_function_bit = 1;
		for (int m = 0; m < 3; m++)
		begin
			primary_osc_mode_field = 2'(m);
			rises(2, 16);
			check(r, m == 0 ? 8 : 0);
		end
		rises(0, 16);
		check(r, 8);
		rises(1, 16);
		check(r, 8);
		osc_pin_function_bit = 0;
		rises(1, 16);
		check(r, 0);
	endtask : t_clk
	task t_lock;
		key(1, 8'h78);
		key(1, 8'h9a);
		key(1, 8'h5a);
		key(0, 8'h46);
		key(0, 8'h57);
		key(0, 8'h3c);
		idle;
		check({osc_ctrl_high, osc_ctrl_low}, 16'h5a3c);
		key(1, 8'h9a);
		key(1, 8'h78);
		key(1, 8'h11);
		key(1, 8'h78);
		key(1, 8'h9a);
		key(0, 8'h22);
		key(1, 8'h22);
		key(0, 8'h99);
		idle;
		check({osc_ctrl_high, osc_ctrl_low}, 16'h5a3c);
		key(1, 8'h78);
		idle;
		key(1, 8'h9a);
		key(1, 8'h66);
		idle;
		check(osc_ctrl_high, 8'h66);
	endtask : t_lock
	task ref_setup(logic [3:0] s, logic [14:0] dv, logic [8:0] tr, logic sl);
		ref_low_wr = 1;
		ref_low_wdata = 0;
		step;
		ref_low_wr = 0;
		// reconfigure only once the module has stopped
		repeat (100) if (ref_ctrl_low[8] !== 1'b0) step;
		check(ref_ctrl_low[8], 0);
		ref_high_wr = 1;
		ref_divisor_wdata = dv;
		ref_trim_wr = 1;
		ref_trim_wdata = tr;
		step;
		ref_high_wr = 0;
		ref_trim_wr = 0;
		ref_low_wr = 1;
		ref_low_wdata = {4'h8, sl, 3'h2, 4'h0, s};
		step;
		ref_low_wr = 0;
		check(ref_ctrl_low[9], 1);
		repeat (200) if (ref_ctrl_low[9] !== 1'b0) step;
		check(ref_ctrl_low[9], 0);
		check({ref_integer_divisor, ref_fraction_trim}, {dv, tr});
		repeat (4) step;
		check(ref_ctrl_low[8], 1);
	endtask : ref_setup
	task t_ref;
		ref_pin_output_enable = 1;
		ref_setup(4'h0, 15'h0, 9'h0, 0);
		rises(3, 16);
		check(r, 8);
		ref_setup(4'h0, 15'h2, 9'h0, 0);
		rises(3, 16);
		check(r, 4);
		ref_setup(4'h0, 15'h3, 9'h100, 0);
		ref_pin_output_enable = 0;
		rises(3, 16);
		check(r, 0);
		ref_pin_output_enable = 1;
		sleep_mode = 1;
		rises(3, 16);
		check(r, 0);
		sleep_mode = 0;
		src1_on = 1;
		ref_setup(4'h1, 15'h0, 9'h0, 1);
		sys_on = 0;
		ref_src_sleep_ok = 16'h0002;
		sleep_mode = 1;
		rises(3, 16);
		check(r, 8);
		ref_src_sleep_ok = 0;
		rises(3, 16);
		check(r, 0);
		sleep_mode = 0;
		sys_on = 1;
	endtask : t_ref
	task t_fs;
		osc_config = 8'h00;
		bk_on = 1;
		repeat (40) step;
		check({failsafe_switched, low_power_rc_enable}, 2'h1);
		sys_on = 0;
		repeat (60) if (failsafe_switched !== 1'b1) step;
		check(failsafe_switched, 1);
		rises(0, 16);
		check(r, 4);
	endtask : t_fs
	initial
	begin
		repeat (4) @(posedge mclk);
		#1;
		rst = 0;
		t_pll;
		t_low_power_rc_source;
		t_clk;
		t_lock;
		t_ref;
		t_fs;
		complete_run;
	end
	initial
	begin
		repeat (5000) @(posedge mclk);
		errors++;
		complete_run;
	end
endmodule : core_clock_and_reference_output_test
